//--- include/rbc_pkg.sv
// package for the reset and brownout supervisor
//
// Behaviour
// [R01] four reset causes merge into chip reset
// [R02] any cause drives reset pin low, starts timer
// [R03] release needs pin, oscillator, count, flash ready
// [R04] reset pin high after release or supply recovery
// [R05] fetch address is zero on reset release
// [R06] all registers at reset values when running
// [R07] first brownout stage raises interrupt request
// [R08] first brownout stage readable as status bit
// [R09] second brownout stage forces chip reset
// [R10] brownout reset held until power-on reset
// [R11] protection pattern in flash, app calls unaffected
// [R12] level one: no jtag, limited boot, sector0
// [R13] level two: no jtag, boot after erase
// [R14] level three: no jtag, boot, override ignored
// [R15] edge and level external interrupt inputs provided
// [R16] enabled external interrupts wake from power-down
// [R17] vector table in lowest gigabyte (software)
// [R18] vector table 128-word aligned (software)
// [R19] timer waits for stable oscillator before run
// [R20] assert at once, release synchronous to clock
package rbc_pkg;

    // ----------------------------------------------------------------
    // timing constants
    // ----------------------------------------------------------------
    localparam int  CLK_MHZ           = 100;        // system clock rate
    localparam int  WAKE_TIME_US      = 100;        // wake-up hold time
    localparam int  WAKE_CYCLES       = WAKE_TIME_US * CLK_MHZ; // cycles held
    localparam int  OSC_STABLE_CYCLES = 64;         // osc good cycles needed

    // ----------------------------------------------------------------
    // vector and protection encodings
    // ----------------------------------------------------------------
    localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000; // fetch after reset
    localparam logic [31:0] PROT_PATTERN_L1  = 32'h1234_5678; // arbitrary pattern
    localparam logic [31:0] PROT_PATTERN_L2  = 32'h8765_4321; // arbitrary pattern
    localparam logic [31:0] PROT_PATTERN_L3  = 32'h4321_8765; // arbitrary pattern
    localparam int          EDGE_IRQ_NUM     = 46;   // edge interrupt inputs
    localparam int          LEVEL_IRQ_NUM    = 4;    // level interrupt inputs

    // protection level
    typedef enum logic [1:0] {
        RBC_PROT_NONE = 2'b00,
        RBC_PROT_ONE  = 2'b01,
        RBC_PROT_TWO  = 2'b10,
        RBC_PROT_THREE = 2'b11
    } rbc_prot_e;

    // sequencer state
    typedef enum logic [1:0] {
        RBC_ST_HOLD  = 2'b00,
        RBC_ST_WAIT  = 2'b01,
        RBC_ST_RUN   = 2'b10
    } rbc_state_e;

    // reset cause inputs
    typedef struct packed {
        logic pin_n;     // external reset pin, low active
        logic watchdog;  // watchdog expiry
        logic por;       // power-on reset
        logic brown_rst; // second brownout stage
    } rbc_cause_s;

    // access gating outputs
    typedef struct packed {
        logic jtag_en;       // debug port allowed
        logic boot_en;       // serial boot allowed
        logic boot_limited;  // limited command set
        logic sector0_lock;  // sector zero writes refused
        logic erase_first;   // updates only after full erase
        logic override_en;   // boot override pin honoured
    } rbc_access_s;

endpackage

//--- rtl/rbc_irq_wake.sv
// external interrupt capture and wake logic
`timescale 1ns/1ps
module rbc_irq_wake #(
    parameter int N_EDGE  = rbc_pkg::EDGE_IRQ_NUM,  // edge inputs
    parameter int N_LEVEL = rbc_pkg::LEVEL_IRQ_NUM  // level inputs
) (
    input  wire logic               clk,         // system clock
    input  wire logic               rst_n,       // synchronised reset
    input  wire logic [N_EDGE-1:0]  edge_in,     // edge pins
    input  wire logic [N_EDGE-1:0]  edge_en,     // edge enables
    input  wire logic [N_LEVEL-1:0] level_in,    // level pins
    input  wire logic [N_LEVEL-1:0] level_en,    // level enables
    input  wire logic [N_EDGE-1:0]  edge_clr,    // clear pending edges
    output logic      [N_EDGE-1:0]  edge_pend,   // pending edge flags
    output logic                    wake         // wake request
);
    // ----------------------------------------------------------------
    // edge capture
    // ----------------------------------------------------------------
    logic [N_EDGE-1:0] edge_d_r;   // previous sample
    wire  [N_EDGE-1:0] edge_rise = edge_in & ~edge_d_r & edge_en; // rising

    // pending flags, a new edge wins over a clear
    // [R15] edge flags held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_d_r  <= '0;
            edge_pend <= '0;
        end else begin
            edge_d_r  <= edge_in;
            edge_pend <= (edge_pend & ~edge_clr) | edge_rise;
        end
    end

    // [R16] wake from enabled inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake <= 1'b0;
        end else begin
            wake <= (|edge_rise) | (|(level_in & level_en));
        end
    end
endmodule

//--- rtl/rbc_top.sv
// reset merge, wake-up timer, brownout and protection gating
`timescale 1ns/1ps
module rbc_top #(
    parameter int WAKE_CNT = rbc_pkg::WAKE_CYCLES, // wake-up hold cycles
    parameter int N_EDGE   = rbc_pkg::EDGE_IRQ_NUM, // edge interrupt inputs
    parameter int N_LEVEL  = rbc_pkg::LEVEL_IRQ_NUM // level interrupt inputs
) (
    input  wire logic                clk,            // system clock
    input  wire logic                nrst,           // supply-usable reset
    input  wire rbc_pkg::rbc_cause_s cause,          // reset causes
    input  wire logic                osc_ok,         // oscillator running
    input  wire logic                flash_init_done, // flash ready
    input  wire logic                brown_stage1,   // supply below stage one
    input  wire logic [31:0]         prot_word,      // protection flash word
    input  wire logic                boot_override_pin, // boot request, low
    input  wire logic [N_EDGE-1:0]   edge_in,        // edge interrupt pins
    input  wire logic [N_EDGE-1:0]   edge_en,        // edge enables
    input  wire logic [N_LEVEL-1:0]  level_in,       // level interrupt pins
    input  wire logic [N_LEVEL-1:0]  level_en,       // level enables
    input  wire logic [N_EDGE-1:0]   edge_clr,       // edge flag clears
    output logic                     reset_output_pin, // reset pin, low active
    output logic                     sys_rst_n,      // internal reset, low
    output logic [31:0]              fetch_addr,     // first fetch address
    output logic                     brown_irq,      // brownout irq request
    output logic                     brown_status,   // brownout status bit
    output rbc_pkg::rbc_access_s     access,         // access gating
    output logic                     serial_boot_enter, // enter serial boot
    output logic [N_EDGE-1:0]        edge_pend,      // pending edge flags
    output logic                     wake_req        // power-down wake
);
    import rbc_pkg::*;

    // ----------------------------------------------------------------
    // reset release synchroniser
    // ----------------------------------------------------------------
    logic rst_s1_r;   // first stage
    logic rst_n_r;    // synchronised reset

    // assert at once, release on a clock edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // cause merge
    // ----------------------------------------------------------------
    // [R01] four causes merged
    wire any_cause = !cause.pin_n | cause.watchdog | cause.por | cause.brown_rst;
    // [R09] second stage forces reset
    // [R10] held until power-on takes over
    wire brown_hold = cause.brown_rst;

    // ----------------------------------------------------------------
    // wake-up timer state
    // ----------------------------------------------------------------
    rbc_state_e  state_r, state_nxt;  // sequencer state
    logic [31:0] cnt_r, cnt_nxt;      // clock count
    logic [7:0]  osc_cnt_r;           // oscillator stable count

    wire osc_stable = (osc_cnt_r == 8'(OSC_STABLE_CYCLES));
    wire cnt_done   = (cnt_r >= 32'(WAKE_CNT));
    // [R03] all four release conditions
    wire release_ok = cause.pin_n & osc_stable & cnt_done & flash_init_done;

    // next state decode
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            RBC_ST_HOLD: begin
                cnt_nxt = '0;
                if (!any_cause) begin
                    state_nxt = RBC_ST_WAIT;
                end
            end
            RBC_ST_WAIT: begin
                if (any_cause) begin
                    state_nxt = RBC_ST_HOLD;
                    cnt_nxt   = '0;
                end else if (release_ok) begin
                    state_nxt = RBC_ST_RUN;
                end else if (!cnt_done) begin
                    cnt_nxt = cnt_r + 32'd1;
                end
            end
            RBC_ST_RUN: begin
                // [R02] any cause restarts timer
                if (any_cause) begin
                    state_nxt = RBC_ST_HOLD;
                end
            end
            default: begin
                state_nxt = RBC_ST_HOLD;
            end
        endcase
    end

    // state and counter registers
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= RBC_ST_HOLD;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // [R19] oscillator must stay good
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            osc_cnt_r <= '0;
        end else if (!osc_ok) begin
            osc_cnt_r <= '0;
        end else if (!osc_stable) begin
            osc_cnt_r <= osc_cnt_r + 8'd1;
        end
    end

    // ----------------------------------------------------------------
    // reset outputs
    // ----------------------------------------------------------------
    wire run_nxt = (state_nxt == RBC_ST_RUN);

    // [R20] internal reset released on an edge
    // [R06] registers held in reset until run
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sys_rst_n <= 1'b0;
        end else begin
            sys_rst_n <= run_nxt;
        end
    end

    // [R04] pin high on release, brownout waits for supply
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            reset_output_pin <= 1'b0;
        end else if (brown_hold) begin
            reset_output_pin <= 1'b0;
        end else begin
            reset_output_pin <= run_nxt;
        end
    end

    // [R05] fetch from address zero
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            fetch_addr <= RESET_FETCH_ADDR;
        end else begin
            fetch_addr <= RESET_FETCH_ADDR;
        end
    end

    // ----------------------------------------------------------------
    // brownout stage one
    // ----------------------------------------------------------------
    // [R07] interrupt request; [R08] status bit
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            brown_irq    <= 1'b0;
            brown_status <= 1'b0;
        end else begin
            brown_irq    <= brown_stage1;
            brown_status <= brown_stage1;
        end
    end

    // ----------------------------------------------------------------
    // code protection decode
    // ----------------------------------------------------------------
    // [R11] level from pattern word
    wire is_l1 = (prot_word == PROT_PATTERN_L1);
    wire is_l2 = (prot_word == PROT_PATTERN_L2);
    wire is_l3 = (prot_word == PROT_PATTERN_L3);
    wire rbc_prot_e prot_lvl = is_l3 ? RBC_PROT_THREE :
                               is_l2 ? RBC_PROT_TWO   :
                               is_l1 ? RBC_PROT_ONE   : RBC_PROT_NONE;
    rbc_prot_e   prot_r;     // level latched on reset release
    rbc_access_s acc_nxt;    // decoded access

    // level caught while reset held
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            prot_r <= RBC_PROT_THREE;
        end else if (state_r != RBC_ST_RUN) begin
            prot_r <= prot_lvl;
        end
    end

    // [R12] [R13] [R14] access per level
    assign acc_nxt.jtag_en      = (prot_r == RBC_PROT_NONE);
    assign acc_nxt.boot_en      = (prot_r != RBC_PROT_THREE);
    assign acc_nxt.boot_limited = (prot_r == RBC_PROT_ONE) | (prot_r == RBC_PROT_TWO);
    assign acc_nxt.sector0_lock = (prot_r == RBC_PROT_ONE);
    assign acc_nxt.erase_first  = (prot_r == RBC_PROT_TWO);
    assign acc_nxt.override_en  = (prot_r != RBC_PROT_THREE);

    // access outputs registered
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            access            <= '0;
            serial_boot_enter <= 1'b0;
        end else begin
            access            <= acc_nxt;
            // [R14] override ignored at level three
            serial_boot_enter <= acc_nxt.override_en & !boot_override_pin
                                 & (state_r != RBC_ST_RUN);
        end
    end

    // ----------------------------------------------------------------
    // external interrupts
    // ----------------------------------------------------------------
    logic wake_w;   // wake from submodule

    rbc_irq_wake #(
        .N_EDGE  (N_EDGE),
        .N_LEVEL (N_LEVEL)
    ) u_irq (
        .clk       (clk),
        .rst_n     (rst_n_r),
        .edge_in   (edge_in),
        .edge_en   (edge_en),
        .level_in  (level_in),
        .level_en  (level_en),
        .edge_clr  (edge_clr),
        .edge_pend (edge_pend),
        .wake      (wake_w)
    );

    // [R16] registered wake request
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            wake_req <= 1'b0;
        end else begin
            wake_req <= wake_w;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_cause;
        any_cause;
    endsequence

    property p_cause_resets;
        @(posedge clk) disable iff (!rst_n_r) s_cause |=> !sys_rst_n; // [R01]
    endproperty
    a_cause_resets: assert property (p_cause_resets) // [R01]
        else $error("cause did not assert internal reset");

    property p_pin_low;
        @(posedge clk) disable iff (!rst_n_r) any_cause |=> !reset_output_pin;
    endproperty
    a_pin_low: assert property (p_pin_low) // [R02]
        else $error("reset pin not low after cause");

    property p_release_cond;
        @(posedge clk) disable iff (!rst_n_r) $rose(sys_rst_n) |-> $past(release_ok);
    endproperty
    a_release_cond: assert property (p_release_cond) // [R03]
        else $error("reset released early");

    property p_brown_pin;
        @(posedge clk) disable iff (!rst_n_r) brown_hold |=> !reset_output_pin;
    endproperty
    a_brown_pin: assert property (p_brown_pin) // [R04]
        else $error("pin high during brownout");

    property p_fetch;
        @(posedge clk) disable iff (!rst_n_r) $rose(sys_rst_n) |-> fetch_addr == 32'h0;
    endproperty
    a_fetch: assert property (p_fetch) // [R05]
        else $error("fetch address not zero");

    property p_brown_irq;
        @(posedge clk) disable iff (!rst_n_r) brown_stage1 |=> brown_irq && brown_status;
    endproperty
    a_brown_irq: assert property (p_brown_irq) // [R07]
        else $error("brownout stage one not flagged");

    sequence s_brown_low;
        brown_hold;
    endsequence

    // [R09] [R10] brownout holds reset
    property p_brown_hold;
        @(posedge clk) disable iff (!rst_n_r) s_brown_low |=> !sys_rst_n && !reset_output_pin;
    endproperty
    a_brown_hold: assert property (p_brown_hold) // [R09]
        else $error("brownout did not hold reset");

    sequence s_level_on;
        sys_rst_n && |(level_in & level_en);
    endsequence

    // [R16] enabled level input wakes
    property p_level_wake;
        @(posedge clk) disable iff (!rst_n_r) s_level_on |-> ##2 wake_req;
    endproperty
    a_level_wake: assert property (p_level_wake) // [R16]
        else $error("enabled level input did not wake");

    property p_l3;
        @(posedge clk) disable iff (!rst_n_r)
            prot_r == RBC_PROT_THREE |=> !access.jtag_en && !access.boot_en && !serial_boot_enter;
    endproperty
    a_l3: assert property (p_l3) // [R14]
        else $error("level three access not refused");

    property p_l1;
        @(posedge clk) disable iff (!rst_n_r)
            prot_r == RBC_PROT_ONE |=> !access.jtag_en && access.sector0_lock;
    endproperty
    a_l1: assert property (p_l1) // [R12]
        else $error("level one gating wrong");

    property p_osc;
        @(posedge clk) disable iff (!rst_n_r) !osc_ok |=> !run_nxt || state_r == RBC_ST_RUN;
    endproperty
    a_osc: assert property (p_osc) // [R19]
        else $error("run entered without stable oscillator");
endmodule

//--- sim/rbc_board.sv
// board side model: supply levels, reset button, watchdog, oscillator, flash
`timescale 1ns/1ps
module rbc_board #(
    parameter int OSC_START = 10    // cycles to oscillator start
) (
    input  wire logic         clk,             // system clock
    input  wire logic [15:0]  supply_mv,       // regulator supply, mV
    input  wire logic         press,           // reset button held
    input  wire logic         wdog,            // watchdog expiry
    input  wire logic         flash_hold,      // keep flash busy
    output rbc_pkg::rbc_cause_s cause,         // reset causes
    output logic              osc_ok,          // oscillator running
    output logic              flash_init_done, // flash ready
    output logic              brown_stage1     // supply below stage one
);
    import rbc_pkg::*;

    // ------------------------------------------------------------
    // supply comparators and start-up
    // ------------------------------------------------------------
    logic [7:0] osc_cnt_r;                 // oscillator start count
    logic       por_w;                     // supply below power-on level
    assign por_w = supply_mv < 16'h03E8;

    initial begin
        cause = '{pin_n: 1'b1, watchdog: 1'b0, por: 1'b1, brown_rst: 1'b1};
        osc_ok = 1'b0;
        flash_init_done = 1'b0;
        brown_stage1 = 1'b1;
        osc_cnt_r = 8'h00;
    end

    // levels change just after the edge, like real pins
    always @(posedge clk) begin
        // pull-up holds the pin high when released
        cause.pin_n <= !press;
        cause.watchdog <= wdog;
        cause.por <= por_w;
        // second stage held all the way down
        cause.brown_rst <= supply_mv < 16'h073A;
        brown_stage1 <= supply_mv < 16'h0898;
        if (por_w) begin
            osc_cnt_r <= 8'h00;
        end else if (osc_cnt_r < OSC_START[7:0]) begin
            osc_cnt_r <= osc_cnt_r + 8'h01;
        end
        osc_ok <= !por_w && (osc_cnt_r == OSC_START[7:0]);
        flash_init_done <= osc_ok && !flash_hold;
    end
endmodule

//--- sim/rbc_top_tb.sv
// self-checking bench for the reset and brownout supervisor
`timescale 1ns/1ps
module rbc_top_tb;
    import rbc_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int WAKE_T = 20;            // shortened wake-up count
    logic        clk = 1'b0;               // system clock
    logic        nrst;                     // supply-usable reset
    logic [15:0] supply_mv;                // board supply
    logic        press, wdog, flash_hold;  // board commands
    rbc_cause_s  cause;                    // reset causes
    logic        osc_ok, flash_init_done, brown_stage1;
    logic [31:0] prot_word;                // protection flash word
    logic        boot_override_pin;        // boot request, low
    logic [45:0] edge_in, edge_en, edge_clr, edge_pend;
    logic [3:0]  level_in, level_en;       // level interrupts
    logic        reset_output_pin, sys_rst_n, brown_irq, brown_status;
    logic        serial_boot_enter, wake_req;
    logic [31:0] fetch_addr;               // first fetch address
    rbc_access_s access;                   // access gating
    logic [31:0] lfsr_r;                   // random source
    logic [31:0] word;                     // protection word in use
    logic [31:0] pat [4];                  // protection patterns
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc_cnt = 0;

    always #5 clk = ~clk;

    rbc_board board (.clk(clk), .supply_mv(supply_mv), .press(press),
        .wdog(wdog), .flash_hold(flash_hold), .cause(cause), .osc_ok(osc_ok),
        .flash_init_done(flash_init_done), .brown_stage1(brown_stage1));

    rbc_top #(.WAKE_CNT(WAKE_T), .N_EDGE(46), .N_LEVEL(4)) dut (.clk(clk),
        .nrst(nrst), .cause(cause), .osc_ok(osc_ok),
        .flash_init_done(flash_init_done), .brown_stage1(brown_stage1),
        .prot_word(prot_word), .boot_override_pin(boot_override_pin),
        .edge_in(edge_in), .edge_en(edge_en), .level_in(level_in),
        .level_en(level_en), .edge_clr(edge_clr),
        .reset_output_pin(reset_output_pin), .sys_rst_n(sys_rst_n),
        .fetch_addr(fetch_addr), .brown_irq(brown_irq), .brown_status(brown_status),
        .access(access), .serial_boot_enter(serial_boot_enter),
        .edge_pend(edge_pend), .wake_req(wake_req));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // gating expected for a protection word
    function automatic rbc_access_s exp_acc(input logic [31:0] w);
        rbc_access_s a;
        a = '0;
        if (w == PROT_PATTERN_L3) return a;
        a.boot_en = 1'b1;
        a.override_en = 1'b1;
        a.jtag_en = (w != PROT_PATTERN_L1) && (w != PROT_PATTERN_L2);
        a.boot_limited = !a.jtag_en;
        a.sector0_lock = (w == PROT_PATTERN_L1);
        a.erase_first = (w == PROT_PATTERN_L2);
        return a;
    endfunction

    task automatic report(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        report({63'h0, got}, {63'h0, exp});
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        report({32'h0, got}, {32'h0, exp});
    endtask

    task automatic check_acc(input rbc_access_s got, input rbc_access_s exp);
        report({58'h0, got}, {58'h0, exp});
    endtask

    task automatic check_pend(input logic [45:0] got, input logic [45:0] exp);
        report({18'h0, got}, {18'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // wait for release under a bound; it must not come before min_c
    task automatic wait_run(input int min_c);
        int n;
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check_bit(sys_rst_n, 1'b1);
        check_bit(n >= min_c, 1'b1);
        check_bit(reset_output_pin, 1'b1);
        check_word(fetch_addr, RESET_FETCH_ADDR);
        check_bit(fetch_addr[31:30] == 2'b00 && fetch_addr[8:0] == 9'h000, 1'b1);
    endtask

    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fail_count++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        supply_mv = 16'h0CE4;
        {press, wdog, flash_hold} = 3'b000;
        prot_word = 32'h0;
        boot_override_pin = 1'b1;
        {edge_in, edge_en, edge_clr} = '0;
        {level_in, level_en} = '0;
        lfsr_r = 32'h74a7399f;
        pat = '{32'h0, PROT_PATTERN_L1, PROT_PATTERN_L2, PROT_PATTERN_L3};
        tick(8);
        nrst <= 1'b1;
        wait_run(OSC_STABLE_CYCLES);
        // every cause, each with its own protection level
        for (int k = 0; k < 4; k++) begin
            lfsr_r = lfsr_next(lfsr_r);
            word = (k == 0) ? lfsr_r : pat[k];
            @(posedge clk);
            prot_word <= word;
            boot_override_pin <= 1'b0;
            press <= (k == 0);
            wdog <= (k == 1);
            supply_mv <= (k == 2) ? 16'h0708 : (k == 3) ? 16'h0384 : 16'h0CE4;
            tick(3);
            @(negedge clk);
            check_bit(sys_rst_n, 1'b0);
            check_bit(reset_output_pin, 1'b0);
            tick(30);
            @(negedge clk);
            check_bit(sys_rst_n, 1'b0);
            check_bit(serial_boot_enter, k != 3);
            @(posedge clk);
            {press, wdog, boot_override_pin} <= 3'b001;
            supply_mv <= 16'h0CE4;
            wait_run((k == 3) ? OSC_STABLE_CYCLES : WAKE_T);
            check_acc(access, exp_acc(word));
        end
        // flash not ready keeps reset
        @(posedge clk);
        {press, flash_hold} <= 2'b11;
        tick(5);
        press <= 1'b0;
        tick(100);
        @(negedge clk);
        check_bit(sys_rst_n, 1'b0);
        @(posedge clk);
        flash_hold <= 1'b0;
        wait_run(0);
        // brownout stages
        @(posedge clk);
        supply_mv <= 16'h07D0;
        tick(3);
        @(negedge clk);
        check_bit(brown_irq, 1'b1);
        check_bit(brown_status, 1'b1);
        check_bit(sys_rst_n, 1'b1);
        @(posedge clk);
        supply_mv <= 16'h0708;
        tick(3);
        @(negedge clk);
        check_bit(reset_output_pin, 1'b0);
        @(posedge clk);
        supply_mv <= 16'h0384;
        tick(40);
        supply_mv <= 16'h0708;
        tick(40);
        @(negedge clk);
        check_bit(reset_output_pin, 1'b0);
        check_bit(sys_rst_n, 1'b0);
        @(posedge clk);
        supply_mv <= 16'h0CE4;
        wait_run(WAKE_T);
        check_bit(brown_status, 1'b0);
        // edge capture, clearing and level wake
        lfsr_r = lfsr_next(lfsr_r);
        @(posedge clk);
        edge_en <= {lfsr_r[13:0], lfsr_r};
        edge_in <= '1;
        tick(1);
        edge_in <= '0;
        tick(3);
        @(negedge clk);
        check_pend(edge_pend, edge_en);
        @(posedge clk);
        edge_clr <= '1;
        tick(1);
        edge_clr <= '0;
        {level_in, level_en} <= 8'hF0;
        tick(3);
        @(negedge clk);
        check_pend(edge_pend, 46'h0);
        check_bit(wake_req, 1'b0);
        @(posedge clk);
        level_en <= 4'h5;
        tick(3);
        @(negedge clk);
        check_bit(wake_req, 1'b1);
        // asynchronous reset in mid-run
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        check_bit(sys_rst_n, 1'b0);
        check_bit(reset_output_pin, 1'b0);
        check_bit(brown_irq, 1'b0);
        tick(8);
        nrst <= 1'b1;
        wait_run(OSC_STABLE_CYCLES);
        stop_test();
    end
endmodule
